// file: rtl/dma_slice_pkg.sv
package dma_slice_pkg;

  typedef enum logic [2:0] {
    write_control_instr        = 3'h0,
    read_control_instr         = 3'h1,
    read_word_counter_instr    = 3'h2,
    read_address_counter_instr = 3'h3,
    reinitialise_instr         = 3'h4,
    load_address_instr         = 3'h5,
    load_word_count_instr      = 3'h6,
    enable_counters_instr      = 3'h7
  } instr_type;

  typedef enum logic [1:0] {
    mode_count_one  = 2'h0,
    mode_count_cmp  = 2'h1,
    mode_addr_cmp   = 2'h2,
    mode_carry_out  = 2'h3
  } mode_type;

  typedef struct packed {
    logic       down;
    mode_type   mode;
  } control_type;

  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe;
  } bus_drive_type;

  localparam int          data_width     = 8;
  localparam int          dir_bit        = 2;
  localparam logic [2:0]  control_reset  = 3'h0;
  localparam logic [7:0]  count_reset    = 8'h00;
  localparam logic [7:0]  count_one      = 8'h01;
  localparam logic [4:0]  control_pad    = 5'h1f;

endpackage : dma_slice_pkg

// file: rtl/slice_counter.sv
// Eight-bit loadable up/down counter with a terminal-carry flag.
module slice_counter (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  load,
  input  wire logic [7:0]            load_value,
  input  wire logic                  step,
  input  wire logic                  down,
  output logic      [7:0]            count_q,
  output logic                       carry_q
);

  logic [7:0] count_d;
  logic       carry_d;

  always_comb begin
    count_d = count_q;
    if (!rstn) begin
      count_d = dma_slice_pkg::count_reset;
    end else if (load) begin
      count_d = load_value;
    end else if (step) begin
      count_d = down ? count_q - 8'h01 : count_q + 8'h01;
    end
    carry_d = down ? (count_d == 8'h00) : (count_d == 8'hff);
  end

  always_ff @(posedge core_clk) begin
    count_q <= count_d;
    carry_q <= carry_d;
  end

endmodule : slice_counter

// file: rtl/dma_address_slice.sv
// Instruction decoder and register datapath of one eight-bit address slice.
// Register updates take effect at the rising edge that samples the instruction.
module dma_address_slice (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] instr_code,
  input  wire logic [7:0] data_in,
  input  wire logic       address_carry_in_n,
  input  wire logic       word_carry_in_n,
  input  wire logic       address_output_enable_n,
  output logic      [7:0] data_out,
  output logic      [7:0] data_oe,
  output logic      [7:0] address_out,
  output logic      [7:0] address_oe,
  output logic            address_carry_out_n,
  output logic            word_carry_out,
  output logic            done
);

  dma_slice_pkg::instr_type   instr;
  dma_slice_pkg::control_type mode_control_reg_q;
  dma_slice_pkg::control_type mode_control_reg_d;
  dma_slice_pkg::bus_drive_type bus_q;
  dma_slice_pkg::bus_drive_type bus_d;
  logic [7:0] address_save_reg_q;
  logic [7:0] address_save_reg_d;
  logic [7:0] count_save_reg_q;
  logic [7:0] count_save_reg_d;
  logic [7:0] current_address_counter;
  logic [7:0] transfer_counter;
  logic       addr_load;
  logic [7:0] addr_value;
  logic       addr_step;
  logic       word_load;
  logic [7:0] word_value;
  logic       word_step;
  logic       word_down;
  logic       addr_carry;
  logic       word_carry;
  logic [7:0] addr_next;
  logic [7:0] word_next;
  logic       done_d;
  logic       done_q;
  logic [7:0] address_out_d;
  logic [7:0] address_oe_d;
  logic [7:0] address_out_q;
  logic [7:0] address_oe_q;
  logic       aco_d;
  logic       aco_q;
  logic       wco_d;
  logic       wco_q;

  assign instr = dma_slice_pkg::instr_type'(instr_code);

  // Control and save registers, plus the load and step controls that steer both counters.
  always_comb begin
    mode_control_reg_d = mode_control_reg_q;
    address_save_reg_d = address_save_reg_q;
    count_save_reg_d   = count_save_reg_q;
    addr_load  = 1'b0;
    addr_value = data_in;
    addr_step  = 1'b0;
    word_load  = 1'b0;
    word_value = data_in;
    word_step  = 1'b0;
    unique case (instr)
      dma_slice_pkg::write_control_instr: begin
        mode_control_reg_d = dma_slice_pkg::control_type'(data_in[2:0]);
      end
      dma_slice_pkg::read_control_instr,
      dma_slice_pkg::read_word_counter_instr,
      dma_slice_pkg::read_address_counter_instr: begin
        // Reads only steer the data bus, so every register holds here.
      end
      dma_slice_pkg::reinitialise_instr: begin
        addr_load  = 1'b1;
        addr_value = address_save_reg_q;
        word_load  = 1'b1;
        if (mode_control_reg_q.mode == dma_slice_pkg::mode_count_cmp) begin
          word_value = dma_slice_pkg::count_reset;
        end else begin
          word_value = count_save_reg_q;
        end
      end
      dma_slice_pkg::load_address_instr: begin
        address_save_reg_d = data_in;
        addr_load          = 1'b1;
      end
      dma_slice_pkg::load_word_count_instr: begin
        count_save_reg_d = data_in;
        word_load        = 1'b1;
        if (mode_control_reg_q.mode == dma_slice_pkg::mode_count_cmp) begin
          word_value = dma_slice_pkg::count_reset;
        end else begin
          word_value = data_in;
        end
      end
      dma_slice_pkg::enable_counters_instr: begin
        addr_step = !address_carry_in_n;
        word_step = !word_carry_in_n &&
                    (mode_control_reg_q.mode != dma_slice_pkg::mode_addr_cmp);
      end
    endcase
    if (!rstn) begin
      mode_control_reg_d = dma_slice_pkg::control_type'(dma_slice_pkg::control_reset);
      address_save_reg_d = dma_slice_pkg::count_reset;
      count_save_reg_d   = dma_slice_pkg::count_reset;
    end
  end

  // Data bus drive: a read shows its value for the cycle that follows the sampling edge.
  always_comb begin
    bus_d.data_out = 8'h00;
    bus_d.data_oe  = 8'h00;
    unique case (instr)
      dma_slice_pkg::read_control_instr: begin
        bus_d.data_out = {dma_slice_pkg::control_pad, mode_control_reg_q};
        bus_d.data_oe  = 8'hff;
      end
      dma_slice_pkg::read_word_counter_instr: begin
        bus_d.data_out = transfer_counter;
        bus_d.data_oe  = 8'hff;
      end
      dma_slice_pkg::read_address_counter_instr: begin
        bus_d.data_out = current_address_counter;
        bus_d.data_oe  = 8'hff;
      end
      dma_slice_pkg::write_control_instr,
      dma_slice_pkg::reinitialise_instr,
      dma_slice_pkg::load_address_instr,
      dma_slice_pkg::load_word_count_instr,
      dma_slice_pkg::enable_counters_instr: begin
        // Writes, loads and counting leave the bus released.
      end
    endcase
    if (!rstn) begin
      bus_d.data_out = 8'h00;
      bus_d.data_oe  = 8'h00;
    end
  end

  assign word_down = (mode_control_reg_q.mode == dma_slice_pkg::mode_count_one);

  slice_counter address_counter_inst (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .load       (addr_load),
    .load_value (addr_value),
    .step       (addr_step),
    .down       (mode_control_reg_q.down),
    .count_q    (current_address_counter),
    .carry_q    (addr_carry)
  );

  slice_counter word_counter_inst (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .load       (word_load),
    .load_value (word_value),
    .step       (word_step),
    .down       (word_down),
    .count_q    (transfer_counter),
    .carry_q    (word_carry)
  );

  // Done and address outputs are registered, so they follow counter state by one cycle.
  always_comb begin
    addr_next = current_address_counter;
    word_next = transfer_counter;
    unique case (mode_control_reg_q.mode)
      dma_slice_pkg::mode_count_one: done_d = (word_next == dma_slice_pkg::count_one);
      dma_slice_pkg::mode_count_cmp: done_d = ((word_next + 8'h01) == count_save_reg_q);
      dma_slice_pkg::mode_addr_cmp:  done_d = (addr_next == word_next);
      dma_slice_pkg::mode_carry_out: done_d = 1'b0;
    endcase
    address_out_d = address_output_enable_n ? 8'h00 : addr_next;
    address_oe_d  = address_output_enable_n ? 8'h00 : 8'hff;
    aco_d = !(addr_carry && !address_carry_in_n);
    wco_d = word_carry && !word_carry_in_n &&
            (mode_control_reg_q.mode != dma_slice_pkg::mode_addr_cmp);
    if (!rstn) begin
      done_d        = 1'b0;
      address_out_d = 8'h00;
      address_oe_d  = 8'h00;
      aco_d         = 1'b1;
      wco_d         = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    mode_control_reg_q <= mode_control_reg_d;
    address_save_reg_q <= address_save_reg_d;
    count_save_reg_q   <= count_save_reg_d;
  end

  // The bus drive is registered so that data_out and data_oe come straight from flip-flops.
  always_ff @(posedge core_clk) begin
    bus_q <= bus_d;
  end

  // Status and address outputs, one edge behind the counter state they report.
  always_ff @(posedge core_clk) begin
    done_q             <= done_d;
    address_out_q      <= address_out_d;
    address_oe_q       <= address_oe_d;
    aco_q              <= aco_d;
    wco_q              <= wco_d;
  end

  assign data_out            = bus_q.data_out;
  assign data_oe             = bus_q.data_oe;
  assign done                = done_q;
  assign address_out         = address_out_q;
  assign address_oe          = address_oe_q;
  assign address_carry_out_n = aco_q;
  assign word_carry_out      = wco_q;

endmodule : dma_address_slice

// file: testbench/dma_slice_asserts.sv
module dma_slice_asserts (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [2:0] instr_code,
  input wire logic [7:0] data_in,
  input wire logic       address_carry_in_n,
  input wire logic       word_carry_in_n,
  input wire logic       address_output_enable_n,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic [7:0] address_out,
  input wire logic [7:0] address_oe,
  input wire logic       address_carry_out_n,
  input wire logic       word_carry_out,
  input wire logic       done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  read_drive_a: assert property (instr_code inside {3'h1, 3'h2, 3'h3} |=> data_oe == 8'hff)
    else $error("read not driven");
  bus_release_a: assert property (data_oe != 8'h00 |-> $past(instr_code) inside {3'h1, 3'h2, 3'h3})
    else $error("bus driven outside a read");
  control_pad_a: assert property (instr_code == 3'h1 |=> data_out[7:3] == 5'h1f)
    else $error("control read pad wrong");
  control_load_a: assert property (
    instr_code == 3'h0 ##1 instr_code == 3'h1 |=> data_out[2:0] == $past(data_in[2:0], 2))
    else $error("control value lost");
  address_load_a: assert property (
    instr_code == 3'h5 ##1 instr_code == 3'h3 |=> data_out == $past(data_in, 2))
    else $error("address load lost");
  address_step_a: assert property (
    instr_code == 3'h5 ##1 instr_code == 3'h7 && !address_carry_in_n ##1 instr_code == 3'h3
    |=> data_out - $past(data_in, 3) inside {8'h01, 8'hff}) else $error("no count step");
  carry_hold_a: assert property (
    instr_code == 3'h5 ##1 instr_code == 3'h7 && address_carry_in_n ##1 instr_code == 3'h3
    |=> data_out == $past(data_in, 3)) else $error("counted without carry");
  mode3_done_a: assert property (instr_code == 3'h0 && data_in[1:0] == 2'h3 |=> ##1 !done)
    else $error("done high in mode 3");
  cover property (instr_code == 3'h7 && !address_carry_in_n && !word_carry_in_n);
  cover property ($rose(done));
  cover property (instr_code == 3'h4 ##1 instr_code == 3'h2);
endmodule : dma_slice_asserts
bind dma_address_slice dma_slice_asserts chk_u (.core_clk, .rstn, .instr_code, .data_in, .address_carry_in_n,
  .word_carry_in_n, .address_output_enable_n, .data_out, .data_oe, .address_out, .address_oe,
  .address_carry_out_n, .word_carry_out, .done);

// file: testbench/carry_driver.sv
module carry_driver (
  input  wire logic core_clk,
  input  wire logic run,
  output logic      address_carry_in_n = 1'b1,
  output logic      word_carry_in_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_q = 8'h5a;
  // Carries stay inactive while the sequencer stalls, and toggle at random while it counts.
  always @(posedge core_clk) begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    address_carry_in_n <= run ? lfsr_q[0] : 1'b1;
    word_carry_in_n <= run ? lfsr_q[3] : 1'b1;
  end
endmodule : carry_driver

// file: testbench/dma_address_slice_bench.sv
module dma_address_slice_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rstn, address_output_enable_n, run, address_carry_in_n, word_carry_in_n;
  logic        address_carry_out_n, word_carry_out, done, e_oe, e_done;
  logic        e_aco, e_wco, ta, tw;
  logic [2:0]  instr_code, cr, pc;
  logic [7:0]  data_in, data_out, data_oe, address_out, address_oe, ac, ar, wc, count_save_reg, e_rd, e_aoe, e_ao;
  logic [31:0] rs = 32'h0000_0018;
  logic [31:0] m;
  int          fail_count, compares, n;
  function automatic logic [31:0] xorshift();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xorshift
  function automatic logic done_of(input logic [1:0] md, input logic [7:0] a, w, r);
    case (md)
      2'h0: return w == 8'h01;
      2'h1: return w + 8'h01 == r;
      2'h2: return a == w;
      default: return 1'b0;
    endcase
  endfunction : done_of
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_flag
  task put(input logic [2:0] i, input logic [7:0] d);
    @(posedge core_clk);
    instr_code <= i;
    data_in <= d;
  endtask : put
  task stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  dma_address_slice dut_u (.core_clk, .rstn, .instr_code, .data_in, .address_carry_in_n, .word_carry_in_n,
    .address_output_enable_n, .data_out, .data_oe, .address_out, .address_oe, .address_carry_out_n,
    .word_carry_out, .done);
  carry_driver carry_u (.core_clk, .run, .address_carry_in_n, .word_carry_in_n);
  // The reference reads the inputs sampled at each edge; outputs are compared at the next falling edge.
  always @(posedge core_clk) begin
    e_oe = rstn && instr_code inside {3'h1, 3'h2, 3'h3};
    e_rd = instr_code == 3'h1 ? {5'h1f, cr} : instr_code == 3'h2 ? wc : ac;
    e_aoe = {8{rstn && !address_output_enable_n}};
    e_ao = e_aoe & ac;
    e_done = rstn && done_of(cr[1:0], ac, wc, count_save_reg);
    e_aco = !(rstn && ta && !address_carry_in_n);
    e_wco = rstn && tw && !word_carry_in_n && cr[1:0] != 2'h2;
    pc = cr;
    if (!rstn) {cr, ac, ar, wc, count_save_reg} = '0;
    else case (instr_code)
      3'h0: cr = data_in[2:0];
      3'h4: begin ac = ar; wc = cr[1:0] == 2'h1 ? 8'h00 : count_save_reg; end
      3'h5: begin ar = data_in; ac = data_in; end
      3'h6: begin count_save_reg = data_in; wc = cr[1:0] == 2'h1 ? 8'h00 : data_in; end
      3'h7: begin
        if (!address_carry_in_n) ac = cr[2] ? ac - 8'h01 : ac + 8'h01;
        if (!word_carry_in_n && cr[1:0] != 2'h2) wc = cr[1:0] == 2'h0 ? wc - 8'h01 : wc + 8'h01;
      end
      default: ;
    endcase
    // Terminal flags take the count after this edge with the direction in force before it.
    ta = pc[2] ? ac == 8'h00 : ac == 8'hff;
    tw = pc[1:0] == 2'h0 ? wc == 8'h00 : wc == 8'hff;
  end
  always @(negedge core_clk) if (rstn) begin
    chk(data_oe, {8{e_oe}});
    if (e_oe) chk(data_out, e_rd);
    chk(address_oe, e_aoe);
    chk(address_out, e_ao);
    chk_flag(done, e_done);
    chk_flag(address_carry_out_n, e_aco);
    chk_flag(word_carry_out, e_wco);
  end
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {rstn, run, address_output_enable_n, instr_code, data_in} = {3'b001, 3'h3, 8'h00};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    run <= 1'b1;
    for (n = 0; n < 32; n++) begin
      m = xorshift();
      put(3'h0, {m[7:3], n[2:0]});
      put(3'h1, m[15:8]);
      put(3'h5, {8{n[3]}});
      put(3'h7, m[23:16]);
      put(3'h3, 8'h00);
      put(3'h6, n[4] ? 8'h01 : 8'hff);
      repeat (3) put(3'h7, m[23:16]);
      put(3'h3, 8'h00);
      put(3'h2, 8'h00);
      put(3'h4, 8'h00);
      put(3'h2, 8'h00);
    end
    for (n = 0; n < 3000; n++) begin
      m = xorshift();
      put(m[2:0], m[15:8]);
      run <= m[16];
      address_output_enable_n <= m[17];
      rstn <= n != 1500;
    end
    put(3'h3, 8'h00);
    stop_test();
  end
  // The tests need about 3400 cycles, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
endmodule : dma_address_slice_bench
